// ---- core_irq_pkg.sv ----
// Shared constants for the core interrupt status and enable block
package core_irq_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CORE_STAT   = 8'h07;
    localparam logic [7:0] OFS_PERIPH_EN   = 8'h17;
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h20;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h21;
    localparam logic [7:0] OFS_EDGE_CFG    = 8'h22;

    // ------------------------------------------------------------
    // Field layout of the core status/control register
    // ------------------------------------------------------------
    localparam int NUM_CORE_SRC  = 3;  // external, timer overflow, timer pin
    localparam int NUM_ENABLES   = 4;  // three core enables plus group enable
    localparam int CORE_FLAG_LSB = 4;  // flag of source i sits at bit 4+i
    localparam int PEND_BIT      = 7;
    localparam int GROUP_EN_BIT  = 3;
    localparam int SRC_EXT       = 0;
    localparam int SRC_T0        = 1;
    localparam int SRC_T0CK      = 2;

    // ------------------------------------------------------------
    // Own event status layout and edge configuration
    // ------------------------------------------------------------
    localparam int EVT_W        = 5;
    localparam int EVT_PEND     = 3;
    localparam int EVT_HAZARD   = 4;
    localparam int EDGE_W       = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG8     = 8'h00;
    localparam logic [4:0] RST_EVT      = 5'h00;
    localparam logic [1:0] RST_EDGE     = 2'h0;

    // ------------------------------------------------------------
    // Vector addresses; reset vector 00h is the default, all peripherals share 20h
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        VEC_RESET  = 8'h00,
        VEC_EXT    = 8'h08,
        VEC_T0     = 8'h10,
        VEC_T0CK   = 8'h18,
        VEC_PERIPH = 8'h20
    } vector_e;

endpackage

// ---- pin_edge_detect.sv ----
// Programmable edge detector for a synchronous pin input
`timescale 1ns/1ps
module pin_edge_detect (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Pin and edge selection (1 = rising, 0 = falling)
    input  wire logic pin_level,
    input  wire logic rising_sel,
    // Detected edge
    output logic      edge_pulse
);
    logic prev_q;
    logic prev_d;

    // Previous level, cleared by reset so no falling edge follows it
    always_comb begin
        prev_d = pin_level;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // One-cycle pulse on the selected transition
    assign edge_pulse = rising_sel ? (pin_level & ~prev_q) : (~pin_level & prev_q);
endmodule

// ---- core_flag_cell.sv ----
// One hardware-set interrupt flag with vector clear and software write
`timescale 1ns/1ps
module core_flag_cell (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Set, hardware clear and software write
    input  wire logic set_evt,
    input  wire logic hw_clr,
    input  wire logic sw_wr,
    input  wire logic sw_val,
    // Flag state
    output logic      flag_q
);
    logic flag_d;

    // Set beats every clear so no event is lost
    always_comb begin
        if (set_evt) begin
            flag_d = 1'b1;
        end else if (hw_clr) begin
            flag_d = 1'b0;
        end else if (sw_wr) begin
            flag_d = sw_val;
        end else begin
            flag_d = flag_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule

// ---- core_interrupt_status_enable.sv ----
// Core interrupt status/control and first peripheral enable register
// Function
// - Pending flag is OR of enabled peripheral flags
// - Pending flag bit is read-only
// - Timer overflow sets flag; vector 10h clears
// - Timer pin edge sets flag; vector 18h clears
// - External pin edge sets flag; vector 08h clears
// - Group enable gates all enabled peripheral interrupts
// - Timer pin edge enable gates its interrupt
// - Timer overflow enable gates its interrupt
// - External pin enable gates its interrupt
// - Enable bit 7 gates port-B change interrupt
// - Enable bits 6..4 gate timers three, two, one
// - Enable bits 3, 2 gate captures two, one
// - Enable bit 1 gates serial transmit empty
// - Enable bit 0 gates serial receive full
// - Flags set regardless of enables or disable
// - Flag set while enable cleared with global disable low: vector 00h
`timescale 1ns/1ps
module core_interrupt_status_enable (
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              sys_rst,
    // Register port
    input  wire logic [core_irq_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [core_irq_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [core_irq_pkg::DATA_W-1:0]   reg_rdata,
    // Event sources
    input  wire logic                              external_interrupt_pin,
    input  wire logic                              timer_clock_input_pin,
    input  wire logic                              timer_zero_overflow,
    input  wire logic [core_irq_pkg::DATA_W-1:0]   periph_request_flags,
    // Core sequencer
    input  wire logic                              global_interrupt_disable,
    input  wire logic                              vector_taken,
    input  wire logic [core_irq_pkg::DATA_W-1:0]   vector_taken_addr,
    output logic                                   core_int_request,
    output logic      [core_irq_pkg::DATA_W-1:0]   request_vector,
    output logic                                   reset_vector_request,
    // Event interrupt
    output logic                                   irq
);
    import core_irq_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Register select, used by every write path and the status read clear
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Vector owned by each core source
    function automatic logic [7:0] src_vector(input int idx);
        case (idx)
            SRC_EXT:  src_vector = VEC_EXT;
            SRC_T0:   src_vector = VEC_T0;
            SRC_T0CK: src_vector = VEC_T0CK;
            default:  src_vector = VEC_RESET;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                    core_wr;
    logic                    pie_wr;
    logic [NUM_CORE_SRC-1:0] src_set;
    logic [NUM_CORE_SRC-1:0] src_clr;
    logic [NUM_CORE_SRC-1:0] flag_q;
    logic [EDGE_W-1:0]       pin_edge;
    logic                    peripheral_pending;
    logic [NUM_ENABLES-1:0]  en_q;
    logic [NUM_ENABLES-1:0]  en_d;
    logic [DATA_W-1:0]       peripheral_interrupt_enable_one_q;
    logic [DATA_W-1:0]       peripheral_interrupt_enable_one_d;
    logic [EDGE_W-1:0]       edge_cfg_q;
    logic [EDGE_W-1:0]       edge_cfg_d;
    logic [NUM_ENABLES-1:0]  all_flags;
    logic [NUM_ENABLES-1:0]  en_cleared;
    logic                    hazard;
    logic                    pend_prev_q;
    logic [EVT_W-1:0]        evt_q;
    logic [EVT_W-1:0]        evt_d;
    logic [EVT_W-1:0]        msk_q;
    logic [EVT_W-1:0]        msk_d;
    logic [EVT_W-1:0]        evt_in;
    logic [DATA_W-1:0]       rdata_q;
    logic [DATA_W-1:0]       rdata_d;
    logic                    req_q;
    logic                    req_d;
    logic [DATA_W-1:0]       vec_q;
    logic [DATA_W-1:0]       vec_d;
    logic                    rst_vec_q;
    logic [NUM_ENABLES-1:0]  active;

    assign core_wr = reg_wr && hit(reg_addr, OFS_CORE_STAT);
    assign pie_wr  = reg_wr && hit(reg_addr, OFS_PERIPH_EN);

    // ------------------------------------------------------------
    // Pin edges and core flags
    // ------------------------------------------------------------

    // Edge detectors: index 0 external pin, index 1 timer clock pin
    generate
        for (genvar e = 0; e < EDGE_W; e++) begin : g_edge
            pin_edge_detect u_edge (
                .clk_sys    (clk_sys),
                .sys_rst    (sys_rst),
                .pin_level  ((e == 0) ? external_interrupt_pin : timer_clock_input_pin),
                .rising_sel (edge_cfg_q[e]),
                .edge_pulse (pin_edge[e])
            );
        end
    endgenerate

    // Set sources ignore every enable and the global disable
    assign src_set[SRC_EXT]  = pin_edge[0];
    assign src_set[SRC_T0]   = timer_zero_overflow;
    assign src_set[SRC_T0CK] = pin_edge[1];

    // Flags are writable by software; vectoring clears them
    generate
        for (genvar s = 0; s < NUM_CORE_SRC; s++) begin : g_flag
            assign src_clr[s] = vector_taken && (vector_taken_addr == src_vector(s));
            core_flag_cell u_flag (
                .clk_sys (clk_sys),
                .sys_rst (sys_rst),
                .set_evt (src_set[s]),
                .hw_clr  (src_clr[s]),
                .sw_wr   (core_wr),
                .sw_val  (reg_wdata[CORE_FLAG_LSB+s]),
                .flag_q  (flag_q[s])
            );
        end
    endgenerate

    // Derived pending flag; never stored, so writes cannot touch it
    assign peripheral_pending = |(periph_request_flags & peripheral_interrupt_enable_one_q);

    // ------------------------------------------------------------
    // Enable registers and edge configuration
    // ------------------------------------------------------------

    // Only the low nibble of the core register holds enables
    always_comb begin
        en_d       = en_q;
        peripheral_interrupt_enable_one_d     = peripheral_interrupt_enable_one_q;
        edge_cfg_d = edge_cfg_q;
        if (core_wr) begin
            en_d = reg_wdata[NUM_ENABLES-1:0];
        end
        if (pie_wr) begin
            peripheral_interrupt_enable_one_d = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, OFS_EDGE_CFG)) begin
            edge_cfg_d = reg_wdata[EDGE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            en_q       <= RST_REG8[NUM_ENABLES-1:0];
            peripheral_interrupt_enable_one_q     <= RST_REG8;
            edge_cfg_q <= RST_EDGE;
        end else begin
            en_q       <= en_d;
            peripheral_interrupt_enable_one_q     <= peripheral_interrupt_enable_one_d;
            edge_cfg_q <= edge_cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Request, vector choice and reset hazard
    // ------------------------------------------------------------

    // Flags aligned with their enables; bit 3 is the group
    assign all_flags = {peripheral_pending, flag_q};
    assign active    = all_flags & en_q;

    // Clearing an enable while its flag is live sends the core home.
    // Software should set the global disable first to avoid this.
    always_comb begin
        en_cleared = core_wr ? (en_q & ~reg_wdata[NUM_ENABLES-1:0]) :
                               {NUM_ENABLES{1'b0}};
        hazard = !global_interrupt_disable &&
                 |(en_cleared & (all_flags | {1'b0, src_set}));
    end

    // External first, then timer overflow, timer pin, peripherals
    always_comb begin
        req_d = !global_interrupt_disable && (|active);
        vec_d = VEC_RESET;
        if (hazard) begin
            vec_d = VEC_RESET;
        end else if (active[SRC_EXT]) begin
            vec_d = VEC_EXT;
        end else if (active[SRC_T0]) begin
            vec_d = VEC_T0;
        end else if (active[SRC_T0CK]) begin
            vec_d = VEC_T0CK;
        end else if (active[GROUP_EN_BIT]) begin
            vec_d = VEC_PERIPH;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            req_q     <= 1'b0;
            vec_q     <= RST_REG8;
            rst_vec_q <= 1'b0;
        end else begin
            req_q     <= req_d;
            vec_q     <= vec_d;
            rst_vec_q <= hazard;
        end
    end

    assign core_int_request     = req_q;
    assign request_vector       = vec_q;
    assign reset_vector_request = rst_vec_q;

    // ------------------------------------------------------------
    // Event status, mask and read port
    // ------------------------------------------------------------

    assign evt_in = {hazard, peripheral_pending & ~pend_prev_q, src_set};

    // Read clears status; a new event in that cycle still lands
    always_comb begin
        evt_d   = evt_q;
        msk_d   = msk_q;
        rdata_d = RST_REG8;
        if (reg_rd && hit(reg_addr, OFS_EVT_STATUS)) begin
            evt_d = {EVT_W{1'b0}};
        end
        evt_d = evt_d | evt_in;
        if (reg_wr && hit(reg_addr, OFS_EVT_MASK)) begin
            msk_d = reg_wdata[EVT_W-1:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_CORE_STAT:  rdata_d = {peripheral_pending, flag_q[SRC_T0CK],
                                           flag_q[SRC_T0], flag_q[SRC_EXT], en_q};
                OFS_PERIPH_EN:  rdata_d = peripheral_interrupt_enable_one_q;
                OFS_EVT_STATUS: rdata_d = {3'h0, evt_q};
                OFS_EVT_MASK:   rdata_d = {3'h0, msk_q};
                OFS_EDGE_CFG:   rdata_d = {6'h00, edge_cfg_q};
                default:        rdata_d = RST_REG8;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            evt_q       <= RST_EVT;
            msk_q       <= RST_EVT;
            rdata_q     <= RST_REG8;
            pend_prev_q <= 1'b0;
        end else begin
            evt_q       <= evt_d;
            msk_q       <= msk_d;
            rdata_q     <= rdata_d;
            pend_prev_q <= peripheral_pending;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = |(evt_q & msk_q);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_pend_read;
        (reg_rd && reg_addr == OFS_CORE_STAT) |=>
            reg_rdata[PEND_BIT] == $past(|(periph_request_flags & peripheral_interrupt_enable_one_q));
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending bit wrong");

    property p_pend_ro;
        (core_wr && reg_wdata[PEND_BIT] && periph_request_flags == 8'h00) |-> ##1
            (periph_request_flags == 8'h00) |-> !peripheral_pending;
    endproperty
    a_pend_ro: assert property (p_pend_ro) else $error("pending bit was writable");

    property p_t0_set_clr;
        (timer_zero_overflow |=> flag_q[SRC_T0]) and
        ((vector_taken && vector_taken_addr == VEC_T0 && !timer_zero_overflow)
            |=> !flag_q[SRC_T0]);
    endproperty
    a_t0_set_clr: assert property (p_t0_set_clr) else $error("timer flag wrong");

    property p_t0ck_set_clr;
        (pin_edge[1] |=> flag_q[SRC_T0CK]) and
        ((vector_taken && vector_taken_addr == VEC_T0CK && !pin_edge[1])
            |=> !flag_q[SRC_T0CK]);
    endproperty
    a_t0ck_set_clr: assert property (p_t0ck_set_clr) else $error("pin flag wrong");

    property p_ext_set_clr;
        (pin_edge[0] |=> flag_q[SRC_EXT]) and
        ((vector_taken && vector_taken_addr == VEC_EXT && !pin_edge[0])
            |=> !flag_q[SRC_EXT]);
    endproperty
    a_ext_set_clr: assert property (p_ext_set_clr) else $error("ext flag wrong");

    property p_group_gate;
        (!global_interrupt_disable && peripheral_pending && en_q[GROUP_EN_BIT])
            |=> core_int_request;
    endproperty
    a_group_gate: assert property (p_group_gate) else $error("group request lost");

    property p_masked_quiet;
        (en_q == 4'h0) |=> !core_int_request;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked request");

    property p_src_gate;
        (!global_interrupt_disable && flag_q[SRC_T0] && en_q[SRC_T0] && !active[SRC_EXT] &&
         !hazard) |=> (core_int_request && request_vector == VEC_T0);
    endproperty
    a_src_gate: assert property (p_src_gate) else $error("timer vector wrong");

    property p_pie_write;
        pie_wr |=> peripheral_interrupt_enable_one_q == $past(reg_wdata);
    endproperty
    a_pie_write: assert property (p_pie_write) else $error("enable write lost");

    property p_set_ignores_en;
        (src_set[SRC_EXT] && !en_q[SRC_EXT] && global_interrupt_disable)
            |=> flag_q[SRC_EXT];
    endproperty
    a_set_ignores_en: assert property (p_set_ignores_en) else $error("flag gated");

    property p_hazard;
        (core_wr && !global_interrupt_disable && en_q[SRC_T0] &&
         !reg_wdata[SRC_T0] && flag_q[SRC_T0]) |=> reset_vector_request;
    endproperty
    a_hazard: assert property (p_hazard) else $error("reset vector missed");

    property p_req_cause;
        core_int_request |-> !$past(global_interrupt_disable) && ($past(active) != 4'h0);
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("request without cause");

    property p_rd_clear;
        (reg_rd && reg_addr == OFS_EVT_STATUS && evt_in == 5'h00) |=> evt_q == 5'h00;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status not cleared");

    c_hazard:  cover property (hazard ##1 reset_vector_request);
    c_periph:  cover property (core_int_request && request_vector == VEC_PERIPH);
    c_vec_clr: cover property (flag_q[SRC_EXT] ##1 src_clr[SRC_EXT] ##1 !flag_q[SRC_EXT]);
    c_irq:     cover property ($rose(irq));
endmodule

// ---- core_irq_tb.sv ----
// Self-checking testbench for the core interrupt status and enable block
`timescale 1ns/1ps
module testbench;
    import core_irq_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       ext_pin = 1'b0;
    logic       tck_pin = 1'b0;
    logic       t0_ovf = 1'b0;
    logic [7:0] periph_flags = 8'h00;
    logic       gdis = 1'b1;
    logic       vec_taken = 1'b0;
    logic [7:0] vec_addr = 8'h00;
    logic       core_req;
    logic [7:0] req_vec;
    logic       rst_vec_req;
    logic       irq;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    core_interrupt_status_enable uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_interrupt_pin(ext_pin), .timer_clock_input_pin(tck_pin),
        .timer_zero_overflow(t0_ovf), .periph_request_flags(periph_flags),
        .global_interrupt_disable(gdis), .vector_taken(vec_taken),
        .vector_taken_addr(vec_addr), .core_int_request(core_req),
        .request_vector(req_vec), .reset_vector_request(rst_vec_req), .irq(irq)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask

    // One-cycle pulse on a signal chosen by index
    task automatic pulse(input int which);
        @(posedge clk_sys);
        if (which == 0) ext_pin <= 1'b1;
        if (which == 1) t0_ovf <= 1'b1;
        if (which == 2) tck_pin <= 1'b1;
        if (which == 3) vec_taken <= 1'b1;
        @(posedge clk_sys);
        ext_pin   <= 1'b0;
        t0_ovf    <= 1'b0;
        tck_pin   <= 1'b0;
        vec_taken <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_values();
        chk("req after reset", 8'h00, {6'h00, core_req, irq});
        rd_chk("core reg reset", OFS_CORE_STAT, 8'h00);
        rd_chk("periph en reset", OFS_PERIPH_EN, 8'h00);
        rd_chk("unmapped read", 8'h30, 8'h00);
    endtask

    // Pin sources see a falling edge (default config); flag set with disable high
    task automatic core_src(input string what, input int src, input logic [7:0] vec);
        logic [7:0] fbit;
        fbit = 8'h10 << src;
        gdis <= 1'b1;
        pulse(src);
        wait_cyc(3);
        rd_chk(what, OFS_CORE_STAT, fbit);
        chk("request while disabled", 8'h00, {7'h00, core_req});
        wr(OFS_CORE_STAT, fbit | (8'h01 << src));
        wait_cyc(3);
        chk("request disabled globally", 8'h00, {7'h00, core_req});
        gdis <= 1'b0;
        wait_cyc(3);
        chk("request enabled", 8'h01, {7'h00, core_req});
        chk("request vector", vec, req_vec);
        vec_addr <= vec;
        pulse(3);
        wait_cyc(3);
        chk("request after vector", 8'h00, {7'h00, core_req});
        rd_chk("flag cleared by vector", OFS_CORE_STAT, 8'h01 << src);
        gdis <= 1'b1;
        wr(OFS_CORE_STAT, 8'h00);
    endtask

    task automatic periph_bits();
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CORE_STAT, 8'h00);
            wr(OFS_PERIPH_EN, 8'h01 << i);
            rd_chk("periph en readback", OFS_PERIPH_EN, 8'h01 << i);
            periph_flags <= 8'hFF ^ (8'h01 << i);
            wait_cyc(2);
            rd_chk("pending other flags", OFS_CORE_STAT, 8'h00);
            periph_flags <= 8'h01 << i;
            gdis <= 1'b0;
            wait_cyc(3);
            rd_chk("pending own flag", OFS_CORE_STAT, 8'h80);
            chk("request without group", 8'h00, {7'h00, core_req});
            wr(OFS_CORE_STAT, 8'h08);
            wait_cyc(3);
            chk("request with group", 8'h01, {7'h00, core_req});
            chk("periph vector", 8'h20, req_vec);
            gdis <= 1'b1;
            periph_flags <= 8'h00;
            wr(OFS_CORE_STAT, 8'h88);
            rd_chk("pending read only", OFS_CORE_STAT, 8'h08);
        end
        wr(OFS_CORE_STAT, 8'h00);
        wr(OFS_PERIPH_EN, 8'h00);
    endtask

    // Clearing an enable while its flag is set and disable is low
    task automatic hazard();
        int seen;
        seen = 0;
        pulse(1);
        wait_cyc(2);
        wr(OFS_CORE_STAT, 8'h22);
        gdis <= 1'b0;
        wait_cyc(2);
        wr(OFS_CORE_STAT, 8'h20);
        // Look just after each edge so the one-cycle pulse is seen settled
        repeat (4) begin
            #1;
            if (rst_vec_req === 1'b1) seen++;
            @(posedge clk_sys);
        end
        chk("reset vector pulses", 8'h01, 8'(seen));
        gdis <= 1'b1;
        wr(OFS_CORE_STAT, 8'h00);
    endtask

    task automatic events_irq();
        // Every event kind has fired by now and nothing has read the status yet
        rd_chk("status flush", OFS_EVT_STATUS, 8'h1F);
        wr(OFS_EVT_MASK, 8'h02);
        rd_chk("mask readback", OFS_EVT_MASK, 8'h02);
        pulse(1);
        wait_cyc(2);
        chk("irq raised", 8'h01, {7'h00, irq});
        rd_chk("status sticky", OFS_EVT_STATUS, 8'h02);
        wait_cyc(1);
        chk("irq after clear", 8'h00, {7'h00, irq});
        wr(OFS_EVT_MASK, 8'h00);
        pulse(1);
        wait_cyc(2);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(8'h30, 8'hFF);
        rd_chk("unmapped write ignored", 8'h30, 8'h00);
        wr(OFS_CORE_STAT, 8'h00);
        // Rising-edge selection: only the leading edge of the pulse counts
        wr(OFS_EDGE_CFG, 8'h03);
        rd_chk("edge cfg readback", OFS_EDGE_CFG, 8'h03);
        pulse(2);
        wait_cyc(2);
        rd_chk("rising edge flag", OFS_CORE_STAT, 8'h40);
    endtask

    // ------------------------------------------------------------
    // Timeout and main sequence
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        wait_cyc(6);
        sys_rst <= 1'b0;
        wait_cyc(2);
        reset_values();
        core_src("external flag", 0, 8'h08);
        core_src("timer overflow flag", 1, 8'h10);
        core_src("timer pin flag", 2, 8'h18);
        periph_bits();
        hazard();
        events_irq();
        test_done();
    end
endmodule
